// file: verilog/sigma_delta_decimation_filter.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - One modulator bit enters each clock; ones density carries the signal.
// - Whole chain decimates the clock rate by 64.
// - First stage is a 384-tap FIR fed with bits at full rate.
// - Second stage is a 151-tap half-band decimating by two.
// - Group delay about 42 words; full-scale step settles within 84.
// - Response is 6 dB down at clock over 128.
// - Band edges scale with the clock: 90.625/96.92/104.6875 kHz at 12.5 MHz.
// - Linear phase, low ripple, steep roll-off.
// - Unipolar words are straight binary from zero to full reference.
// - Bipolar words are twos complement spanning plus and minus half reference.
// - No rejection at multiples of the clock rate.
// - A 14-bit cycle counter; only its top bit is used, for the settled flag; the 9-bit tap counter paces the words.
// - Counter advances each rising clock; all I/O is synchronous to it except i_rst, which clears asynchronously.
// - Sync resets the filter, counter, output word and settled flag.
module sigma_delta_decimation_filter (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst,
  input  wire logic                   i_sync,
  input  wire logic                   i_mod_bit,
  input  wire logic                   i_bipolar,
  output logic [sdf_pkg::OUT_W-1:0]   o_data,
  output logic                        o_data_valid,
  output logic                        o_settled
);
  import sdf_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0]           cnt;
    logic [TAP_W-1:0]           tap;
    logic [FIR_PHASES-1:0][ACC_W-1:0] acc;
    fir_word_s                  fir;
    logic                       settled;
    logic [OUT_W-1:0]           data;
    logic                       valid;
  } top_state_s;

  localparam top_state_s TOP_RST = '0;

  top_state_s q;
  top_state_s d;
  hb_word_s   hb;

  ////////////////////////////////////////////////////////////////////////////
  // Second stage runs on first-stage words, one every 32 clocks.
  halfband_decimator u_halfband (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_clear   (i_sync),
    .i_word    (q.fir),
    .o_word    (hb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // The 384-tap sum is built by twelve staggered accumulators, each offset
  // by 32 bits, so exactly one finishes every 32 clocks. This trades a
  // 384-bit history for twelve small adders with a cheap triangle weight.
  always_comb begin
    int             idx;
    acc_t           wgt;
    acc_t           sum;
    hb_out_t        trim;
    hb_out_t        sat;
    idx  = 0;
    wgt  = '0;
    sum  = '0;
    trim = '0;
    sat  = '0;
    d         = q;
    d.valid   = 1'b0;
    d.fir.vld = 1'b0;
    d.cnt     = q.cnt + 14'h0001;
    d.tap     = (q.tap == TAP_LAST) ? '0 : q.tap + 9'h001;
    // Sticky ready flag once the counter top bit has been reached.
    if (q.cnt[SETTLE_BIT]) begin
      d.settled = 1'b1;
    end
    for (int j = 0; j < FIR_PHASES; j++) begin
      idx = int'(q.tap) - j * FIR_DEC;
      if (idx < 0) begin
        idx = idx + FIR_TAPS;
      end
      wgt = fir_coef(idx);
      sum = $signed(q.acc[j]) + (i_mod_bit ? wgt : -wgt);
      if (idx == FIR_TAPS - 1) begin
        d.fir.vld = 1'b1;
        d.fir.val = fir_t'(sum);
        d.acc[j]  = '0;
      end else begin
        d.acc[j]  = sum;
      end
    end
    // Rescale by 7/8 so full scale lands just inside 16 bits, then clamp.
    if (hb.vld) begin
      trim = hb.val - (hb.val >>> OUT_TRIM);
      sat  = (trim > SAT_HI) ? SAT_HI : ((trim < SAT_LO) ? SAT_LO : trim);
      d.data  = i_bipolar ? sat[OUT_W-1:0]
                          : sat[OUT_W-1:0] ^ OFFSET_BIN;
      d.valid = 1'b1;
    end
    // Sync holds everything at zero while high; nothing here is calibration.
    if (i_sync) begin
      d = TOP_RST;
    end
  end

  // State register.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q <= TOP_RST;
    end else begin
      q <= d;
    end
  end

  assign o_data       = q.data;
  assign o_data_valid = q.valid;
  assign o_settled    = q.settled;

endmodule : sigma_delta_decimation_filter

`default_nettype wire

// file: verilog/sdf_pkg.sv
`default_nettype none

package sdf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and decimation figures.
  localparam int          CNT_W       = 14;
  localparam int          CONV_W      = 6;
  localparam int          DEC_TOTAL   = 64;
  localparam int          SETTLE_BIT  = 13;
  localparam int          FIR_TAPS    = 384;
  localparam int          FIR_DEC     = 32;
  localparam int          FIR_PHASES  = FIR_TAPS / FIR_DEC;
  localparam int          FIR_HALF    = FIR_TAPS / 2;
  localparam int          TAP_W       = 9;
  localparam logic [8:0]  TAP_LAST    = 9'h17f;
  localparam logic [4:0]  SLOT_LAST   = 5'h1f;
  localparam int          ACC_W       = 18;
  localparam int          FIR_W       = 17;

  ////////////////////////////////////////////////////////////////////////////
  // Half-band stage figures.
  localparam int          HB_TAPS     = 151;
  localparam int          HB_CENTER   = 75;
  localparam int          HB_PAIRS    = 38;
  localparam int          HB_HALF     = HB_PAIRS / 2;
  localparam logic [4:0]  HB_STEP_LAST = 5'h12;
  localparam int          HB_COEF_W   = 14;
  localparam int          HB_ACC_W    = 36;
  localparam int          HB_CENTER_COEF = 4096;
  localparam int          HB_NUM      = 2608;
  localparam int          HB_SHIFT    = 13;
  localparam int          HB_OUT_W    = 20;

  ////////////////////////////////////////////////////////////////////////////
  // Output word figures.
  localparam int          OUT_W       = 16;
  localparam int          OUT_TRIM    = 3;
  localparam logic [15:0] OFFSET_BIN  = 16'h8000;
  localparam logic signed [HB_OUT_W-1:0] SAT_HI = 20'sh07fff;
  localparam logic signed [HB_OUT_W-1:0] SAT_LO = -20'sh08000;

  typedef logic signed [ACC_W-1:0]     acc_t;
  typedef logic signed [FIR_W-1:0]     fir_t;
  typedef logic signed [HB_COEF_W-1:0] hb_coef_t;
  typedef logic signed [HB_OUT_W-1:0]  hb_out_t;

  typedef struct packed {
    logic vld;
    fir_t val;
  } fir_word_s;

  typedef struct packed {
    logic    vld;
    hb_out_t val;
  } hb_word_s;

  // Triangular first-stage weight: symmetric, so the phase stays linear.
  function automatic acc_t fir_coef(input int idx);
    int w;
    w = (idx < FIR_HALF) ? idx + 1 : FIR_TAPS - idx;
    return acc_t'(w);
  endfunction : fir_coef

  // Windowed half-band weight for the pair at odd distance 2p+1 from centre.
  function automatic hb_coef_t hb_coef(input int p);
    int d;
    int mag;
    d   = 2 * p + 1;
    mag = (HB_NUM * (HB_CENTER + 1 - d)) / ((HB_CENTER + 1) * d);
    return (p % 2 == 0) ? hb_coef_t'(mag) : hb_coef_t'(-mag);
  endfunction : hb_coef

endpackage : sdf_pkg

`default_nettype wire

// file: verilog/halfband_decimator.sv
`timescale 1ns/1ps
`default_nettype none

module halfband_decimator (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  input  wire logic              i_clear,
  input  wire sdf_pkg::fir_word_s i_word,
  output var sdf_pkg::hb_word_s  o_word
);
  import sdf_pkg::*;

  typedef struct packed {
    logic [HB_TAPS-1:0][FIR_W-1:0] hist;
    logic                          odd;
    logic                          busy;
    logic [4:0]                    step;
    logic signed [HB_ACC_W-1:0]    acc;
    hb_word_s                      out;
  } hb_state_s;

  localparam hb_state_s HB_RST = '0;

  hb_state_s q;
  hb_state_s d;

  ////////////////////////////////////////////////////////////////////////////
  // Constant weights, one per symmetric tap pair.
  hb_coef_t coef [HB_PAIRS];
  genvar g;
  generate
    for (g = 0; g < HB_PAIRS; g++) begin : g_coef
      assign coef[g] = hb_coef(g);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Two pairs per cycle keep the sum inside 19 cycles, well under the
  // 32-cycle gap between input words, so the history never shifts mid-sum.
  always_comb begin
    int                         pa;
    int                         pb;
    logic signed [FIR_W:0]      sa;
    logic signed [FIR_W:0]      sb;
    logic signed [HB_ACC_W-1:0] term;
    pa   = 0;
    pb   = 0;
    sa   = '0;
    sb   = '0;
    term = '0;
    d         = q;
    d.out.vld = 1'b0;
    if (q.busy) begin
      pa   = int'(q.step);
      pb   = pa + HB_HALF;
      sa   = (FIR_W+1)'($signed(q.hist[HB_CENTER - 2*pa - 1]))
           + (FIR_W+1)'($signed(q.hist[HB_CENTER + 2*pa + 1]));
      sb   = (FIR_W+1)'($signed(q.hist[HB_CENTER - 2*pb - 1]))
           + (FIR_W+1)'($signed(q.hist[HB_CENTER + 2*pb + 1]));
      term = HB_ACC_W'(sa * coef[pa]) + HB_ACC_W'(sb * coef[pb]);
      d.acc = q.acc + term;
      d.step = q.step + 5'h01;
      if (q.step == HB_STEP_LAST) begin
        d.busy    = 1'b0;
        d.out.vld = 1'b1;
        d.out.val = hb_out_t'((q.acc + term) >>> HB_SHIFT);
      end
    end
    // Every input shifts in; every second one starts an output sum.
    if (i_word.vld) begin
      d.hist = {q.hist[HB_TAPS-2:0], i_word.val};
      d.odd  = ~q.odd;
      if (q.odd) begin
        d.busy = 1'b1;
        d.step = '0;
        // The centre tap after this shift is the word now at HB_CENTER-1.
        d.acc  = HB_ACC_W'($signed(q.hist[HB_CENTER-1])) * HB_ACC_W'(HB_CENTER_COEF);
      end
    end
    if (i_clear) begin
      d = HB_RST;
    end
  end

  // State register.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q <= HB_RST;
    end else begin
      q <= d;
    end
  end

  assign o_word = q.out;

endmodule : halfband_decimator

`default_nettype wire

// file: tb/mod_bit_source.sv
`timescale 1ns/1ps
`default_nettype none

// Modulator stand-in: 0 all zeros, 1 all ones, 2 alternating (mid-scale).
module mod_bit_source (
  input  wire logic       i_clk_sys,
  input  wire logic [1:0] i_mode,
  output logic            o_bit
);
  logic phase_q = 1'b0;

  // One fresh bit per rising edge, so density tracks the mode.
  always @(posedge i_clk_sys) begin
    phase_q <= ~phase_q;
    o_bit   <= (i_mode == 2'h1) | ((i_mode == 2'h2) & phase_q);
  end
endmodule : mod_bit_source

`default_nettype wire

// file: tb/sigma_delta_decimation_filter_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module sdf_checker (
  input wire logic                      i_clk_sys,
  input wire logic                      i_rst,
  input wire logic                      i_sync,
  input wire logic                      i_mod_bit,
  input wire logic                      i_bipolar,
  input wire logic [sdf_pkg::OUT_W-1:0] o_data,
  input wire logic                      o_data_valid,
  input wire logic                      o_settled
);
  logic [13:0] run_q;
  logic [6:0]  gap_q;
  logic        seen_q;

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Cycles since restart and since the last word; both saturate to avoid a wrap.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) {run_q, gap_q, seen_q} <= '0;
    else if (i_sync) {run_q, gap_q, seen_q} <= '0;
    else begin
      run_q  <= run_q + {13'h0, run_q != 14'h3fff};
      gap_q  <= o_data_valid ? 7'h0 : gap_q + {6'h0, gap_q != 7'h7f};
      seen_q <= seen_q | o_data_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_valid_pulse: assert property (o_data_valid |=> !o_data_valid)
    else $error("valid pulse wider than one cycle");
  a_word_period: assert property (o_data_valid && seen_q |-> gap_q == 7'h3f)
    else $error("word spacing is not 64 clocks");
  a_data_holds: assert property (!o_data_valid && !$past(i_sync) |-> $stable(o_data))
    else $error("data changed without a valid pulse");
  a_sync_clears: assert property (i_sync |=>
    o_data == '0 && !o_data_valid && !o_settled)
    else $error("sync did not clear outputs");
  // The first full pair of first-stage words closes on bit 63, so the first
  // pulse is seen with the run counter at 85.
  a_first_word: assert property (!seen_q && o_data_valid |-> run_q == 14'd85)
    else $error("first word out of window");
  a_word_due: assert property (run_q == 14'd86 |-> seen_q)
    else $error("no word by the expected time");
  a_settle_time: assert property ($rose(o_settled) |-> run_q inside {[8190:8196]})
    else $error("settled flag at wrong time");
  a_settle_holds: assert property (o_settled && !i_sync |=> o_settled)
    else $error("settled flag dropped");
endmodule : sdf_checker

bind sigma_delta_decimation_filter sdf_checker chk_u (.i_clk_sys, .i_rst, .i_sync,
  .i_mod_bit, .i_bipolar, .o_data, .o_data_valid, .o_settled);

`default_nettype wire

// file: tb/test_sigma_delta_decimation_filter.sv
`timescale 1ns/1ps
`default_nettype none

module test_sigma_delta_decimation_filter;
  import sdf_pkg::*;
  logic             i_clk_sys = 1'b0;
  logic             i_rst     = 1'b1;
  logic             i_sync    = 1'b0;
  logic             i_bipolar = 1'b1;
  logic [1:0]       mode      = 2'h0;
  logic             mod_bit;
  logic [OUT_W-1:0] o_data;
  logic             o_data_valid;
  logic             o_settled;
  int               miscompares = 0;
  int               cmp_count   = 0;
  int               cycles      = 0;
  int               n;

  sigma_delta_decimation_filter dut_u (.i_clk_sys, .i_rst, .i_sync, .i_mod_bit(mod_bit),
    .i_bipolar, .o_data, .o_data_valid, .o_settled);
  mod_bit_source src_u (.i_clk_sys, .i_mode(mode), .o_bit(mod_bit));

  // Free-running clock; the cycle ceiling catches a hung wait.
  always #20 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Edges until the next word; gives up after 9000 so a stuck output shows.
  task automatic next_word(output int k);
    k = 0;
    do begin
      @(posedge i_clk_sys);
      #1 k++;
    end while (o_data_valid !== 1'b1 && k < 9000);
  endtask : next_word

  // Restart, check clearing and first-word timing, skip filter fill, judge level.
  task automatic t_dc(input logic [1:0] m, input logic b, input logic [15:0] lo, hi);
    logic [15:0] v;
    @(posedge i_clk_sys);
    mode      <= m;
    i_bipolar <= b;
    i_sync    <= 1'b1;
    @(posedge i_clk_sys);
    i_sync <= 1'b0;
    #1 chk(o_data === 16'h0 && !o_data_valid && !o_settled, o_data, 16'h0);
    // First-stage word 2 closes on bit 63; its handover, 19 half-band steps
    // and the output register put the first pulse on edge 85 of the run.
    next_word(n);
    chk(n == 85, 16'(n), 16'h55);
    while (o_settled !== 1'b1) next_word(n);
    next_word(n);
    v = o_data ^ (b ? 16'h8000 : 16'h0);
    chk(v >= lo && v <= hi, o_data, lo);
    next_word(n);
    chk(n == 64, 16'(n), 16'h40);
  endtask : t_dc

  // Full-scale step: midpoint near the group delay, final level within 84 words.
  task automatic t_step;
    int k;
    t_dc(2'h0, 1'b1, 16'h0, 16'h1000);
    mode <= 2'h1;
    // Bipolar words are flipped to offset binary so the climb compares unsigned.
    for (k = 1; k < 90 && (o_data ^ 16'h8000) < 16'h8000; k++) next_word(n);
    chk(k >= 36 && k <= 46, 16'(k), 16'h2a);
    for (; k < 90 && (o_data ^ 16'h8000) < 16'hf000; k++) next_word(n);
    chk(k <= 84, 16'(k), 16'h54);
  endtask : t_step

  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  // Each density in both codings; bipolar is compared after flipping the msb.
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    for (int b = 0; b < 2; b++) begin
      t_dc(2'h1, b[0], 16'hf000, 16'hffff);
      t_dc(2'h0, b[0], 16'h0000, 16'h1000);
      t_dc(2'h2, b[0], 16'h7f00, 16'h80ff);
    end
    t_step();
    summarize();
  end
endmodule : test_sigma_delta_decimation_filter

`default_nettype wire
